/* eri_map.svh */
// register offsets, field positions and reset values for the exception return unit
// Functional notes
// - hazard barrier stalls issue until all earlier execution hazards are resolved
// - on superscalar or early cores the barrier issues like a superscalar no-op
// - enable instruction writes old status word to named register, then sets enable bit
// - with no destination named, register zero is used and old value dropped
// - status read and enable-bit set are indivisible; no interrupt taken between
// - without coprocessor 0 access, enable instruction traps and leaves status unchanged
// - with error level set return uses error address and clears it, else exception
// - with compressed set, return pc drops bit 0 and bit 0 selects instruction set
// - standard return clears the load-linked reservation flag; here a reservation set in the same cycle wins
// - return has no delay slot; next executed instruction is at return address
// - return resolves coprocessor 0 hazards before fetch at return address
// - keep-link return behaves as standard return but keeps reservation flag
// - keep-link support is reported by a readable configuration flag
`ifndef ERI_MAP_SVH
`define ERI_MAP_SVH
`define ERI_OFS_STATUS      8'h00
`define ERI_OFS_EXC_ADDR    8'h04
`define ERI_OFS_ERR_ADDR    8'h08
`define ERI_OFS_SHADOW      8'h0c
`define ERI_OFS_CONFIG      8'h10
`define ERI_OFS_CORE_STATE  8'h14
`define ERI_ST_IE           0
`define ERI_ST_EXL          1
`define ERI_ST_ERL          2
`define ERI_ST_BEV          22
`define ERI_STATUS_RESET    32'h0040_0004
`define ERI_STATUS_WMASK    32'h0040_0007
`define ERI_SH_CSS_LSB      0
`define ERI_SH_PSS_LSB      6
`define ERI_SH_HSS_LSB      26
`define ERI_CFG_LLB         0
`define ERI_CFG_ISA_LSB     14
`define ERI_CFG_REV_LSB     24
`define ERI_HAZARD_CYCLES   3
`endif

/* eri_pkg.sv */
// types shared by the exception return unit
package eri_pkg;
    typedef enum logic [2:0] {
        OP_NONE    = 3'h0,
        OP_EI      = 3'h1,
        OP_EXCEPTION_RETURN_INSTR    = 3'h2,
        OP_EXCEPTION_RETURN_KEEP_LINK  = 3'h3,
        OP_BARRIER = 3'h4,
        OP_SUPERSCALAR_NOP   = 3'h5
    } op_t;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DRAIN = 2'b01,
        ST_RET   = 2'b11
    } state_t;
endpackage : eri_pkg

/* hazard_tracker.sv */
// counts down an outstanding coprocessor 0 execution hazard
`timescale 1ns/100ps
`include "eri_map.svh"
module hazard_tracker #(
    parameter int CYCLES = `ERI_HAZARD_CYCLES
) (
    input  wire logic sys_clk,      // core clock
    input  wire logic sys_rst,      // sync reset
    input  wire logic hazardSet,    // a cop0 state change happened
    output logic      pending       // hazard not yet settled
);
    import eri_pkg::*;
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] left;

    initial begin
        if (CYCLES < 1) $error("hazard window must be at least one cycle");
    end

    // restart the window on every new change
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            left <= '0;
        end else if (hazardSet) begin
            left <= W'(CYCLES);
        end else if (left != '0) begin
            left <= left - W'(1);
        end
    end

    assign pending = (left != '0);
endmodule : hazard_tracker

/* ret_addr_sel.sv */
// picks the return target and instruction set from the level flags
`timescale 1ns/100ps
module ret_addr_sel #(
    parameter bit COMPRESSED = 1'b1
) (
    input  wire logic        errLevel,     // error level flag
    input  wire logic        excLevel,     // exception level flag
    input  wire logic [31:0] excAddr,      // exception return address
    input  wire logic [31:0] errAddr,      // error return address
    input  wire logic [1:0]  isaCfg,       // compressed set config field
    output logic [31:0]      targetPc,     // pc to resume at
    output logic             targetIsa,    // instruction set to resume in
    output logic             nextErr,      // error level after return
    output logic             nextExc,      // exception level after return
    output logic             useExc        // exception path was taken
);
    import eri_pkg::*;
    logic [31:0] temp;

    always_comb begin
        temp      = errLevel ? errAddr : excAddr;
        nextErr   = 1'b0;
        nextExc   = errLevel ? excLevel : 1'b0;
        useExc    = !errLevel;
        if (COMPRESSED || isaCfg != 2'h0) begin
            targetPc  = {temp[31:1], 1'b0};
            targetIsa = temp[0];
        end else begin
            targetPc  = temp;
            targetIsa = 1'b0;
        end
    end
endmodule : ret_addr_sel

/* exception_return_irq_enable.sv */
// privileged enable, return and barrier control with its cop0 register slave
`timescale 1ns/100ps
`include "eri_map.svh"
module exception_return_irq_enable #(
    parameter int       ARCH_REV      = 2,
    parameter bit       SUPERSCALAR   = 1'b0,
    parameter bit       COMPRESSED    = 1'b1,
    parameter bit [1:0] ISA_CFG       = 2'h1,
    parameter bit       KEEP_LINK_OK  = 1'b1,
    parameter bit [3:0] HIGHEST_SET   = 4'h3,
    parameter int       HAZARD_CYCLES = `ERI_HAZARD_CYCLES
) (
    input  wire logic        sys_clk,       // core clock
    input  wire logic        sys_rst,       // sync reset, active high
    input  wire logic        hsel,          // slave select
    input  wire logic [31:0] haddr,         // byte address
    input  wire logic [1:0]  htrans,        // transfer type
    input  wire logic        hwrite,        // write when high
    input  wire logic [2:0]  hsize,         // transfer size
    input  wire logic        hready,        // bus ready in
    input  wire logic [31:0] hwdata,        // write data
    output logic [31:0]      hrdata,        // read data
    output logic             hreadyout,     // slave ready
    output logic             hresp,         // always okay
    input  wire logic        instrValid,    // pipeline offers an instruction
    input  wire eri_pkg::op_t instrOp,      // which privileged operation
    input  wire logic [4:0]  instrDest,     // destination register number
    input  wire logic        instrHasDest,  // destination was named
    input  wire logic        cop0Usable,    // cop0 access allowed now
    input  wire logic        linkSet,       // load-linked set reservation
    output logic             instrAccept,   // instruction taken this cycle
    output logic             gprWe,         // register write pulse
    output logic [4:0]       gprAddr,       // register number
    output logic [31:0]      gprData,       // old status word
    output logic             copUnusable,   // coprocessor unusable trap pulse
    output logic             redirectValid, // resume pulse
    output logic [31:0]      redirectPc,    // resume address
    output logic             instruction_set_select,       // current instruction set
    output logic             flushNext,     // kill the following instruction
    output logic             issueStall,    // hold instruction issue
    output logic             irqBlock,      // no interrupt may be taken
    output logic             irqEnable,     // interrupt enable bit
    output logic             linkFlag       // reservation flag
);
    import eri_pkg::*;

    initial begin
        if (ARCH_REV < 1) $error("architecture revision must be at least 1");
        if (HAZARD_CYCLES < 1) $error("hazard window must be at least one cycle");
    end

    // decodes a bus offset to a register slot, 7 when unmapped
    function automatic logic [2:0] slot_of(input logic [7:0] ofs);
        unique case (ofs)
            `ERI_OFS_STATUS:     slot_of = 3'h0;
            `ERI_OFS_EXC_ADDR:   slot_of = 3'h1;
            `ERI_OFS_ERR_ADDR:   slot_of = 3'h2;
            `ERI_OFS_SHADOW:     slot_of = 3'h3;
            `ERI_OFS_CONFIG:     slot_of = 3'h4;
            `ERI_OFS_CORE_STATE: slot_of = 3'h5;
            default:             slot_of = 3'h7;
        endcase
    endfunction : slot_of

    logic [31:0] status;
    logic [31:0] excAddr;
    logic [31:0] errAddr;
    logic [3:0]  curSet;
    logic [3:0]  prevSet;
    state_t      state;
    op_t         heldOp;
    logic        bubble;
    logic        phWrite;
    logic        phRead;
    logic [2:0]  phSlot;
    logic        hazardPending;
    logic        hazardSet;
    logic [31:0] targetPc;
    logic        targetIsa;
    logic        nextErr;
    logic        nextExc;
    logic        useExc;
    logic        doEi;
    logic        doRet;
    logic        trap;
    logic        busWr;
    logic [31:0] shadowWord;
    logic [31:0] configWord;
    logic [31:0] coreWord;

    // address phase capture; writes only for whole-word transfers, reads of any size
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            phWrite <= 1'b0;
            phRead  <= 1'b0;
            phSlot  <= 3'h7;
        end else if (hready) begin
            phWrite <= hsel && htrans[1] && hwrite && hsize == 3'h2;
            phRead  <= hsel && htrans[1] && !hwrite;
            phSlot  <= slot_of(haddr[7:0]);
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign busWr     = phWrite;

    // readable words built from live state; config word from parameters only
    assign shadowWord = {2'h0, HIGHEST_SET, 16'h0, prevSet, 2'h0, curSet};
    assign configWord = {ARCH_REV[7:0], 8'h0, ISA_CFG, 13'h0, KEEP_LINK_OK};
    assign coreWord   = {26'h0, state, hazardPending, instruction_set_select, linkFlag, irqBlock};

    // read data registered at the end of the address phase
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hrdata <= 32'h0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (slot_of(haddr[7:0]))
                3'h0:    hrdata <= status;
                3'h1:    hrdata <= excAddr;
                3'h2:    hrdata <= errAddr;
                3'h3:    hrdata <= shadowWord;
                3'h4:    hrdata <= configWord;
                3'h5:    hrdata <= coreWord;
                default: hrdata <= 32'h0;
            endcase
        end
    end

    ret_addr_sel #(
        .COMPRESSED (COMPRESSED)
    ) u_sel (
        .errLevel  (status[`ERI_ST_ERL]),
        .excLevel  (status[`ERI_ST_EXL]),
        .excAddr   (excAddr),
        .errAddr   (errAddr),
        .isaCfg    (ISA_CFG),
        .targetPc  (targetPc),
        .targetIsa (targetIsa),
        .nextErr   (nextErr),
        .nextExc   (nextExc),
        .useExc    (useExc)
    );

    hazard_tracker #(
        .CYCLES (HAZARD_CYCLES)
    ) u_haz (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .hazardSet (hazardSet),
        .pending   (hazardPending)
    );

    // instruction intake and trap decisions
    assign instrAccept = (state == ST_IDLE) && !bubble;
    assign trap  = instrAccept && instrValid && !cop0Usable &&
                   (instrOp == OP_EI || instrOp == OP_EXCEPTION_RETURN_INSTR || instrOp == OP_EXCEPTION_RETURN_KEEP_LINK);
    assign doEi  = instrAccept && instrValid && cop0Usable && instrOp == OP_EI && ARCH_REV >= 2;
    assign doRet = (state == ST_RET);
    assign hazardSet = doEi || (busWr && phSlot <= 3'h3);

    // barrier drains hazards, returns drain then resume
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state  <= ST_IDLE;
            heldOp <= OP_NONE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (instrAccept && instrValid && cop0Usable &&
                        (instrOp == OP_EXCEPTION_RETURN_INSTR || instrOp == OP_EXCEPTION_RETURN_KEEP_LINK)) begin
                        state  <= ST_DRAIN;
                        heldOp <= instrOp;
                    end else if (instrAccept && instrValid && instrOp == OP_BARRIER &&
                                 !SUPERSCALAR && ARCH_REV >= 2) begin
                        state  <= ST_DRAIN;
                        heldOp <= OP_BARRIER;
                    end
                end
                ST_DRAIN: begin
                    if (!hazardPending) begin
                        state <= (heldOp == OP_BARRIER) ? ST_IDLE : ST_RET;
                    end
                end
                ST_RET: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // superscalar no-op, and barrier in its no-op form, costs one issue slot
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bubble <= 1'b0;
        end else begin
            bubble <= instrAccept && instrValid && (instrOp == OP_SUPERSCALAR_NOP ||
                      (instrOp == OP_BARRIER && (SUPERSCALAR || ARCH_REV < 2)));
        end
    end

    assign issueStall = (state != ST_IDLE) || bubble;
    assign irqBlock   = doEi || (state != ST_IDLE);
    assign irqEnable  = status[`ERI_ST_IE];

    // status word: bus write first, instruction effects on top
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status <= `ERI_STATUS_RESET;
        end else begin
            if (busWr && phSlot == 3'h0) begin
                status <= hwdata & `ERI_STATUS_WMASK;
            end
            if (doEi) begin
                status[`ERI_ST_IE] <= 1'b1;
            end else if (doRet) begin
                status[`ERI_ST_ERL] <= nextErr;
                status[`ERI_ST_EXL] <= nextExc;
            end
        end
    end

    // return address registers are software owned
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            excAddr <= 32'h0;
            errAddr <= 32'h0;
        end else begin
            if (busWr && phSlot == 3'h1) excAddr <= hwdata;
            if (busWr && phSlot == 3'h2) errAddr <= hwdata;
        end
    end

    // shadow set fields
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            curSet  <= 4'h0;
            prevSet <= 4'h0;
        end else begin
            if (busWr && phSlot == 3'h3) begin
                curSet  <= hwdata[`ERI_SH_CSS_LSB +: 4];
                prevSet <= hwdata[`ERI_SH_PSS_LSB +: 4];
            end
            if (doRet && useExc && ARCH_REV >= 2 && HIGHEST_SET != 4'h0 &&
                !status[`ERI_ST_BEV]) begin
                curSet <= prevSet;
            end
        end
    end

    // register write of the old status word
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            gprWe   <= 1'b0;
            gprAddr <= 5'h0;
            gprData <= 32'h0;
        end else begin
            gprWe   <= doEi;
            if (doEi) begin
                gprAddr <= instrHasDest ? instrDest : 5'h0;
                gprData <= status;
            end
        end
    end

    // trap and redirect pulses
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            copUnusable   <= 1'b0;
            redirectValid <= 1'b0;
            redirectPc    <= 32'h0;
            flushNext     <= 1'b0;
        end else begin
            copUnusable   <= trap;
            redirectValid <= doRet;
            flushNext     <= instrAccept && instrValid && cop0Usable &&
                             (instrOp == OP_EXCEPTION_RETURN_INSTR || instrOp == OP_EXCEPTION_RETURN_KEEP_LINK);
            if (doRet) begin
                redirectPc <= targetPc;
            end
        end
    end

    // instruction set mode
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            instruction_set_select <= 1'b0;
        end else if (doRet) begin
            instruction_set_select <= targetIsa;
        end
    end

    // reservation flag: a set in the same cycle as a clear wins
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            linkFlag <= 1'b0;
        end else if (linkSet) begin
            linkFlag <= 1'b1;
        end else if (doRet && heldOp == OP_EXCEPTION_RETURN_INSTR) begin
            linkFlag <= 1'b0;
        end else if (doRet && heldOp == OP_EXCEPTION_RETURN_KEEP_LINK && !KEEP_LINK_OK) begin
            linkFlag <= 1'b0;
        end
    end
    // keep-link form leaves the flag alone when supported
endmodule : exception_return_irq_enable

/* exception_return_irq_enable_assertions.sv */
// concurrent checks on the enable, return and barrier control ports
`timescale 1ns/100ps
module exception_return_irq_enable_assertions #(
    parameter bit KEEP_LINK_OK = 1'b1
) (
    input wire logic         sys_clk,       // core clock
    input wire logic         sys_rst,       // sync reset
    input wire logic         instrValid,    // instruction offered
    input wire eri_pkg::op_t instrOp,       // operation
    input wire logic [4:0]   instrDest,     // destination number
    input wire logic         instrHasDest,  // destination named
    input wire logic         cop0Usable,    // cop0 access allowed
    input wire logic         linkSet,       // reservation set
    input wire logic         instrAccept,   // instruction taken
    input wire logic         gprWe,         // register write
    input wire logic [4:0]   gprAddr,       // register number
    input wire logic         copUnusable,   // trap pulse
    input wire logic         redirectValid, // resume pulse
    input wire logic         flushNext,     // kill next
    input wire logic         issueStall,    // issue held
    input wire logic         irqBlock,      // interrupts held off
    input wire logic         irqEnable,     // enable bit
    input wire logic         linkFlag       // reservation flag
);
    import eri_pkg::*;
    logic acc;
    logic retKeep; // return in flight keeps the link
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // an instruction is taken at this edge
    assign acc = instrValid && instrAccept;
    // remember which return form was taken last
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            retKeep <= 1'b0;
        end else if (acc && cop0Usable && (instrOp == OP_EXCEPTION_RETURN_INSTR || instrOp == OP_EXCEPTION_RETURN_KEEP_LINK)) begin
            retKeep <= (instrOp == OP_EXCEPTION_RETURN_KEEP_LINK);
        end
    end
    property p_ei_write;
        acc && instrOp == OP_EI && cop0Usable && instrHasDest
            |=> gprWe && gprAddr == $past(instrDest) && irqEnable;
    endproperty
    a_ei_write: assert property (p_ei_write) else $error("enable write wrong");
    property p_ei_zero;
        acc && instrOp == OP_EI && cop0Usable && !instrHasDest |=> gprWe && gprAddr == 5'h00;
    endproperty
    a_ei_zero: assert property (p_ei_zero) else $error("enable without dest wrong");
    property p_ei_atomic;
        acc && instrOp == OP_EI && cop0Usable |-> irqBlock or (##1 irqBlock);
    endproperty
    a_ei_atomic: assert property (p_ei_atomic) else $error("interrupt window open");
    property p_ei_trap;
        acc && instrOp == OP_EI && !cop0Usable |=> copUnusable && !gprWe;
    endproperty
    a_ei_trap: assert property (p_ei_trap) else $error("enable trap missing");
    property p_ret_trap;
        acc && !cop0Usable && (instrOp == OP_EXCEPTION_RETURN_INSTR || instrOp == OP_EXCEPTION_RETURN_KEEP_LINK)
            |=> (copUnusable && !flushNext) ##1 !redirectValid [*2];
    endproperty
    a_ret_trap: assert property (p_ret_trap) else $error("return trap missing");
    property p_no_slot;
        acc && cop0Usable && (instrOp == OP_EXCEPTION_RETURN_INSTR || instrOp == OP_EXCEPTION_RETURN_KEEP_LINK) |=> flushNext;
    endproperty
    a_no_slot: assert property (p_no_slot) else $error("slot not flushed");
    property p_ret_barrier;
        acc && cop0Usable && (instrOp == OP_EXCEPTION_RETURN_INSTR || instrOp == OP_EXCEPTION_RETURN_KEEP_LINK)
            |=> !instrAccept [*2] ##[1:6] redirectValid;
    endproperty
    a_ret_barrier: assert property (p_ret_barrier) else $error("return timing wrong");
    property p_exception_return_instr_clear;
        redirectValid && !retKeep && !$past(linkSet) |-> !linkFlag;
    endproperty
    a_exception_return_instr_clear: assert property (p_exception_return_instr_clear) else $error("link not cleared");
    property p_keep_link;
        redirectValid && retKeep && KEEP_LINK_OK |-> linkFlag == ($past(linkFlag) || $past(linkSet));
    endproperty
    a_keep_link: assert property (p_keep_link) else $error("link lost");
    property p_barrier;
        acc && instrOp == OP_BARRIER |=> issueStall ##[1:5] !issueStall;
    endproperty
    a_barrier: assert property (p_barrier) else $error("barrier stall wrong");
    property p_superscalar_nop;
        acc && instrOp == OP_SUPERSCALAR_NOP |=> !instrAccept ##1 instrAccept;
    endproperty
    a_superscalar_nop: assert property (p_superscalar_nop) else $error("no-op bubble wrong");
    c_ei: cover property (acc && instrOp == OP_EI && cop0Usable);
    c_ret: cover property (redirectValid);
    c_trap: cover property (copUnusable);
    c_stall: cover property (acc && instrOp == OP_BARRIER ##1 issueStall);
endmodule : exception_return_irq_enable_assertions

bind exception_return_irq_enable exception_return_irq_enable_assertions #(
    .KEEP_LINK_OK(KEEP_LINK_OK)
) u_chk (
    .sys_clk, .sys_rst, .instrValid, .instrOp, .instrDest, .instrHasDest, .cop0Usable,
    .linkSet, .instrAccept, .gprWe, .gprAddr, .copUnusable, .redirectValid, .flushNext,
    .issueStall, .irqBlock, .irqEnable, .linkFlag
);

/* exception_return_irq_enable_tb_top.sv */
// self-checking bench for the enable, return and barrier control
`timescale 1ns/100ps
`include "eri_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module exception_return_irq_enable_tb_top;
    import eri_pkg::*;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, gprData, redirectPc;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'h0;
    logic [4:0]  instrDest = 5'h00, gprAddr;
    op_t         instrOp = OP_NONE;
    logic        instrValid = 1'b0, instrHasDest = 1'b0, cop0Usable = 1'b0, linkSet = 1'b0;
    logic        hreadyout, hresp, instrAccept, gprWe, copUnusable, redirectValid, instruction_set_select;
    logic        flushNext, issueStall, irqBlock, irqEnable, linkFlag;
    int          err_total = 0, n_checks = 0, cycles = 0;

    // 125 MHz core clock; the single slave drives the bus ready
    always #4 sys_clk = ~sys_clk;
    assign hready = hreadyout;

    exception_return_irq_enable dut (
        .sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
        .hrdata, .hreadyout, .hresp, .instrValid, .instrOp, .instrDest, .instrHasDest,
        .cop0Usable, .linkSet, .instrAccept, .gprWe, .gprAddr, .gprData, .copUnusable,
        .redirectValid, .redirectPc, .instruction_set_select, .flushNext, .issueStall, .irqBlock,
        .irqEnable, .linkFlag
    );

    // single word transfer: address phase, then data phase, each held until ready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'h2;
        do begin
            @(posedge sys_clk);
        end while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin
            @(posedge sys_clk);
        end while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    // offer one instruction until taken, then stop at the following negedge
    task automatic issue(input op_t op, input logic hasDest, input logic usable);
        instrValid <= 1'b1;
        instrOp <= op;
        instrDest <= 5'h05;
        instrHasDest <= hasDest;
        cop0Usable <= usable;
        do begin
            @(posedge sys_clk);
        end while (instrAccept !== 1'b1);
        instrValid <= 1'b0;
        @(negedge sys_clk);
    endtask : issue

    // reset values, read-only config and an unmapped place
    task automatic t_regs;
        logic [31:0] v;
        bus(1'b0, `ERI_OFS_STATUS, 32'h0, v);
        `CHK({v, hresp, hreadyout}, {32'h0040_0004, 1'b0, 1'b1})
        bus(1'b1, `ERI_OFS_CONFIG, 32'hffff_ffff, v);
        bus(1'b0, `ERI_OFS_CONFIG, 32'h0, v);
        `CHK(v, 32'h0200_4001)
        bus(1'b0, 8'h20, 32'h0, v);
        `CHK(v, 32'h0)
    endtask : t_regs

    // enable with and without a named destination
    task automatic t_ei;
        issue(OP_EI, 1'b1, 1'b1);
        `CHK({gprWe, gprAddr, gprData, irqEnable}, {1'b1, 5'h05, 32'h0040_0004, 1'b1})
        @(posedge sys_clk);
        issue(OP_EI, 1'b0, 1'b1);
        `CHK({gprWe, gprAddr, gprData}, {1'b1, 5'h00, 32'h0040_0005})
        @(posedge sys_clk);
        issue(OP_BARRIER, 1'b0, 1'b1);
        `CHK(issueStall, 1'b1)
        @(posedge sys_clk);
    endtask : t_ei

    // every privileged form traps without cop0 access and leaves status alone
    task automatic t_trap;
        logic [31:0] v;
        op_t ops[3] = '{OP_EI, OP_EXCEPTION_RETURN_INSTR, OP_EXCEPTION_RETURN_KEEP_LINK};
        bus(1'b1, `ERI_OFS_STATUS, 32'h0, v);
        foreach (ops[i]) begin
            issue(ops[i], 1'b1, 1'b0);
            `CHK({copUnusable, gprWe, flushNext}, 3'b100)
            @(posedge sys_clk);
        end
        bus(1'b0, `ERI_OFS_STATUS, 32'h0, v);
        `CHK(v, 32'h0)
    endtask : t_trap

    // one return from a prepared status, checking target, mode, link and levels
    task automatic t_ret(input op_t op, input logic [31:0] st, pc, stExp, shExp,
                         input logic isa, lk);
        logic [31:0] v;
        int n;
        bus(1'b1, `ERI_OFS_EXC_ADDR, 32'h0000_1235, v);
        bus(1'b1, `ERI_OFS_ERR_ADDR, 32'h0000_2000, v);
        bus(1'b1, `ERI_OFS_SHADOW, 32'h0000_0040, v);
        bus(1'b1, `ERI_OFS_STATUS, st, v);
        linkSet <= 1'b1;
        @(posedge sys_clk);
        linkSet <= 1'b0;
        issue(op, 1'b0, 1'b1);
        `CHK({flushNext, instrAccept, irqBlock}, 3'b101)
        n = 0;
        while (redirectValid !== 1'b1 && n < 12) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK({redirectValid, redirectPc, instruction_set_select, linkFlag}, {1'b1, pc, isa, lk})
        @(posedge sys_clk);
        bus(1'b0, `ERI_OFS_STATUS, 32'h0, v);
        `CHK(v, stExp)
        bus(1'b0, `ERI_OFS_SHADOW, 32'h0, v);
        `CHK(v, shExp)
    endtask : t_ret

    // barrier stalls while a status hazard is pending; the no-op leaves one bubble
    task automatic t_issue;
        logic [31:0] v;
        int n;
        bus(1'b1, `ERI_OFS_STATUS, 32'h0, v);
        issue(OP_BARRIER, 1'b0, 1'b1);
        `CHK(issueStall, 1'b1)
        n = 0;
        while (issueStall !== 1'b0 && n < 12) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK(issueStall, 1'b0)
        @(posedge sys_clk);
        issue(OP_SUPERSCALAR_NOP, 1'b0, 1'b1);
        `CHK(instrAccept, 1'b0)
        @(negedge sys_clk);
        `CHK(instrAccept, 1'b1)
        @(posedge sys_clk);
    endtask : t_issue

    // counts and verdict
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_total++;
            end_sim();
        end
    end

    // main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_regs();
        t_ei();
        t_trap();
        t_ret(OP_EXCEPTION_RETURN_INSTR, 32'h2, 32'h1234, 32'h0, 32'h0c00_0041, 1'b1, 1'b0);
        t_ret(OP_EXCEPTION_RETURN_KEEP_LINK, 32'h6, 32'h2000, 32'h2, 32'h0c00_0040, 1'b0, 1'b1);
        t_ret(OP_EXCEPTION_RETURN_INSTR, 32'h0040_0002, 32'h1234, 32'h0040_0000, 32'h0c00_0040, 1'b1, 1'b0);
        t_issue();
        end_sim();
    end
endmodule : exception_return_irq_enable_tb_top
